// *** hdl/pwr_pkg.sv ***
package pwr_pkg;
    // ======================================================
    // Register map
    localparam logic [7:0] SPC_OFFSET     = 8'h8f;
    localparam logic [7:0] SPC_RESET      = 8'h3f;
    localparam logic [7:0] SPC_IMPL_MASK  = 8'hbf;
    localparam logic [7:0] STAT_OFFSET    = 8'h90;
    // Control field positions
    localparam int HIB_EN_BIT   = 7;
    localparam int REF_OFF_BIT  = 5;
    localparam int LS_OFF_BIT   = 4;
    localparam int OSC_OFF_BIT  = 3;
    localparam int CMP_OFF_BIT  = 2;
    localparam int TEMP_OFF_BIT = 1;
    localparam int CONV_OFF_BIT = 0;
    // Wake source indices
    localparam int NUM_IRQ      = 6;
    localparam int WK_PUSHBUTTON_PIN      = 0;
    localparam int WK_PORTC     = 1;
    localparam int WK_SERIAL    = 2;
    localparam int WK_CMP       = 3;
    localparam int WK_ADDONE    = 4;
    localparam int WK_ADTMR     = 5;
    localparam logic [12:0] IRQ_VECTOR = 13'h0004;
    // Power states
    typedef enum logic [1:0] {
        ST_RUN   = 2'b00,
        ST_SLEEP = 2'b01,
        ST_HIB   = 2'b10,
        ST_WAKE  = 2'b11
    } pstate_t;
endpackage

// *** hdl/pwr_sync_if.sv ***
`timescale 1ns/1ps
`default_nettype none
// ======================================================
// Synchronised pin levels between top and synchroniser
interface pwr_sync_if;
    logic       master_clear_pin_n_raw;
    logic       wdt_to_raw;
    logic       master_clear_pin_n_s;
    logic       wdt_to_s;
    modport sync (input master_clear_pin_n_raw, input wdt_to_raw, output master_clear_pin_n_s, output wdt_to_s);
    modport top  (output master_clear_pin_n_raw, output wdt_to_raw, input master_clear_pin_n_s, input wdt_to_s);
endinterface
`default_nettype wire

// *** hdl/pin_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
// ======================================================
// Three-stage synchroniser, change accepted when stages 2 and 3 agree
module pin_sync (
    // Clock and reset
    input  wire logic   mclk,
    input  wire logic   sys_rst,
    // Pins
    pwr_sync_if.sync    sif
);
    logic [1:0] s1_ff;
    logic [1:0] s2_ff;
    logic [1:0] s3_ff;
    logic [1:0] out_ff;

    // Shift chain and agreement filter
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            s1_ff  <= 2'h1;
            s2_ff  <= 2'h1;
            s3_ff  <= 2'h1;
            out_ff <= 2'h1;
        end else begin
            s1_ff <= {sif.wdt_to_raw, sif.master_clear_pin_n_raw};
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            for (int i = 0; i < 2; i++) begin
                if (s2_ff[i] == s3_ff[i]) out_ff[i] <= s3_ff[i];
            end
        end
    end

    assign sif.master_clear_pin_n_s = out_ff[0];
    assign sif.wdt_to_s = out_ff[1];
endmodule
`default_nettype wire

// *** hdl/sleep_hibernate_power_control.sv ***
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Sleep clears watchdog counter, keeps it counting; main oscillator stops only if osc-sleep-off is 1.
// - Sleep entry clears power-down flag and sets time-out flag.
// - CPU clock stopped in sleep and hibernate, running otherwise.
// - In sleep main oscillator runs if osc-sleep-off is 0, stops if 1.
// - Osc-sleep-off bit ignored while awake; oscillator always runs awake.
// - I/O ports hold their pre-sleep drive state across sleep.
// - Wake on reset pin, watchdog, pushbutton, port C, serial, comparator, A/D events.
// - Reset-pin wake performs full reset; other wakes resume execution.
// - Watchdog time-out wake clears time-out flag.
// - Sleep instruction prefetches the next program address.
// - Interrupt wakes only with its own enable, regardless of global enable.
// - After interrupt wake run next instruction, then vector if global enable.
// - Watchdog counter cleared on every wake-up.
// - Pending enabled interrupt at sleep entry wakes immediately.
// - Sleep with hibernate enable set enters hibernate instead.
// - Hibernate forces watchdog off, disables pull-ups, gates input buffers.
// - Hibernate wakes on same sources except watchdog time-out.
// - Watchdog runs only when configured enabled and not hibernating.
// - Power-on reset circuit active except in sleep and hibernate.
// - Reference-off bit powers down bandgap, low-voltage detector, bias.
// - Converter, level-shift, comparator, temperature off bits power down those networks.
// - Control register resets to 3Fh, bit 6 reads zero.
module sleep_hibernate_power_control
    import pwr_pkg::*;
(
    // Clock and reset
    input  wire logic              mclk,
    input  wire logic              sys_rst,
    // Wishbone slave
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    input  wire logic              wb_we_i,
    input  wire logic [7:0]        wb_adr_i,
    input  wire logic [31:0]       wb_dat_i,
    input  wire logic [3:0]        wb_sel_i,
    output logic [31:0]            wb_dat_o,
    output logic                   wb_ack_o,
    output logic                   wb_err_o,
    // CPU side
    input  wire logic              sleep_exec,
    input  wire logic [12:0]       pc_next,
    input  wire logic              global_irq_enable,
    input  wire logic              watchdog_config_enable,
    input  wire logic [NUM_IRQ-1:0] irq_flags,
    input  wire logic [NUM_IRQ-1:0] irq_enables,
    input  wire logic              next_insn_done,
    output logic                   cpu_clk_en,
    output logic                   prefetch_req,
    output logic [12:0]            prefetch_addr,
    output logic                   vector_req,
    output logic [12:0]            vector_addr,
    output logic                   device_reset,
    // Status flags
    output logic                   power_down_flag,
    output logic                   timeout_flag,
    // Watchdog
    input  wire logic              wdt_timeout_pin,
    output logic                   wdt_clear,
    output logic                   wdt_run,
    // Pins and port hold
    input  wire logic              master_clear_pin,
    output logic                   port_hold,
    output logic                   pullup_disable,
    output logic                   input_buffer_gate,
    // Analog power and oscillators
    output logic                   main_osc_en,
    output logic                   por_enable,
    output logic                   ref_pwr_en,
    output logic                   lvl_shift_pwr_en,
    output logic                   cmp_pwr_en,
    output logic                   temp_pwr_en,
    output logic                   conv_pwr_en
);
    // ======================================================
    // Synchronisers
    pwr_sync_if sif ();
    assign sif.master_clear_pin_n_raw = master_clear_pin;
    assign sif.wdt_to_raw = wdt_timeout_pin;

    pin_sync u_sync (
        .mclk    (mclk),
        .sys_rst (sys_rst),
        .sif     (sif)
    );

    logic master_clear_pin_low;
    logic wdt_to;
    logic wdt_to_d_ff;
    logic wdt_to_rise;
    assign master_clear_pin_low    = ~sif.master_clear_pin_n_s;
    assign wdt_to      = sif.wdt_to_s;
    assign wdt_to_rise = wdt_to & ~wdt_to_d_ff;

    // ======================================================
    // Register bus
    logic [7:0]  spc_ff;
    logic [31:0] nxt_dat;
    logic        hit_spc;
    logic        hit_stat;
    logic        req;

    assign req      = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
    assign hit_spc  = (wb_adr_i == SPC_OFFSET);
    assign hit_stat = (wb_adr_i == STAT_OFFSET);

    pstate_t st_ff;
    pstate_t nxt_st;
    logic    gie_latch_ff;
    logic    wake_irq_ff;

    // Read data mux
    always_comb begin
        nxt_dat = 32'h0;
        if (hit_spc) nxt_dat = {24'h0, spc_ff & SPC_IMPL_MASK};
        else if (hit_stat) nxt_dat = {28'h0, st_ff, timeout_flag, power_down_flag};
    end

    // Bus answer, one cycle after request
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            wb_ack_o <= 1'b0;
            wb_err_o <= 1'b0;
            wb_dat_o <= 32'h0;
        end else begin
            wb_ack_o <= req & (hit_spc | hit_stat);
            wb_err_o <= req & ~(hit_spc | hit_stat);
            wb_dat_o <= req ? nxt_dat : 32'h0;
        end
    end

    // Control register, full reset on power-on or on master clear outside the run state
    always_ff @(posedge mclk) begin
        if (sys_rst || device_reset) begin
            spc_ff <= SPC_RESET;
        end else if (req && hit_spc && wb_we_i && wb_sel_i[0]) begin
            spc_ff <= wb_dat_i[7:0] & SPC_IMPL_MASK;
        end
    end

    // ======================================================
    // Power state machine
    logic [NUM_IRQ-1:0] irq_wake;
    logic               any_irq;
    logic               wdt_wake;
    assign irq_wake = irq_flags & irq_enables;
    assign any_irq  = |irq_wake;
    assign wdt_wake = (st_ff == ST_SLEEP) & wdt_to_rise;

    always_comb begin
        nxt_st = st_ff;
        case (st_ff)
            ST_RUN: begin
                if (sleep_exec && !any_irq)
                    nxt_st = spc_ff[HIB_EN_BIT] ? ST_HIB : ST_SLEEP;
                else if (sleep_exec)
                    nxt_st = ST_WAKE;
            end
            ST_SLEEP, ST_HIB: begin
                if (any_irq || wdt_wake) nxt_st = ST_WAKE;
            end
            ST_WAKE: begin
                if (next_insn_done) nxt_st = ST_RUN;
            end
            default: nxt_st = ST_RUN;
        endcase
        if (master_clear_pin_low) nxt_st = ST_RUN;
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) st_ff <= ST_RUN;
        else st_ff <= nxt_st;
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) wdt_to_d_ff <= 1'b0;
        else wdt_to_d_ff <= wdt_to;
    end

    // Wake cause: interrupt vs watchdog, global enable sampled at wake
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            wake_irq_ff  <= 1'b0;
            gie_latch_ff <= 1'b0;
        end else if (nxt_st == ST_WAKE && st_ff != ST_WAKE) begin
            wake_irq_ff  <= any_irq;
            gie_latch_ff <= global_irq_enable;
        end
    end

    // ======================================================
    // Status flags
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            power_down_flag <= 1'b1;
            timeout_flag    <= 1'b1;
        end else if (st_ff == ST_RUN && sleep_exec && !master_clear_pin_low) begin
            power_down_flag <= 1'b0;
            timeout_flag    <= 1'b1;
        end else if (wdt_wake && !master_clear_pin_low) begin
            timeout_flag    <= 1'b0;
        end
    end

    // ======================================================
    // CPU handshake outputs
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            prefetch_req  <= 1'b0;
            prefetch_addr <= 13'h0;
            vector_req    <= 1'b0;
            vector_addr   <= IRQ_VECTOR;
            device_reset  <= 1'b0;
        end else begin
            prefetch_req <= (st_ff == ST_RUN) & sleep_exec;
            if (st_ff == ST_RUN && sleep_exec)
                prefetch_addr <= pc_next;
            vector_req   <= (st_ff == ST_WAKE) & next_insn_done & wake_irq_ff & gie_latch_ff;
            device_reset <= master_clear_pin_low & (st_ff != ST_RUN);
        end
    end

    // ======================================================
    // Clocks, watchdog and power enables
    logic asleep;
    assign asleep = (nxt_st == ST_SLEEP) | (nxt_st == ST_HIB);

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            cpu_clk_en        <= 1'b1;
            main_osc_en       <= 1'b1;
            por_enable        <= 1'b1;
            port_hold         <= 1'b0;
            pullup_disable    <= 1'b0;
            input_buffer_gate <= 1'b0;
            wdt_clear         <= 1'b0;
            wdt_run           <= 1'b0;
        end else begin
            cpu_clk_en        <= ~asleep;
            main_osc_en       <= ~asleep | ((nxt_st == ST_SLEEP) & ~spc_ff[OSC_OFF_BIT]);
            por_enable        <= ~asleep;
            port_hold         <= asleep;
            pullup_disable    <= (nxt_st == ST_HIB);
            input_buffer_gate <= (nxt_st == ST_HIB);
            wdt_clear         <= ((st_ff == ST_RUN) & sleep_exec)
                                 | (((st_ff == ST_SLEEP) | (st_ff == ST_HIB)) & (nxt_st != st_ff));
            wdt_run           <= watchdog_config_enable & (nxt_st != ST_HIB);
        end
    end

    // Analog module power from control bits
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            ref_pwr_en       <= 1'b0;
            lvl_shift_pwr_en <= 1'b0;
            cmp_pwr_en       <= 1'b0;
            temp_pwr_en      <= 1'b0;
            conv_pwr_en      <= 1'b0;
        end else begin
            ref_pwr_en       <= ~spc_ff[REF_OFF_BIT];
            lvl_shift_pwr_en <= ~spc_ff[LS_OFF_BIT];
            cmp_pwr_en       <= ~spc_ff[CMP_OFF_BIT];
            temp_pwr_en      <= ~spc_ff[TEMP_OFF_BIT];
            conv_pwr_en      <= ~spc_ff[CONV_OFF_BIT];
        end
    end

    // ======================================================
    // Assertions
    property p_sleep_flags;
        @(posedge mclk) disable iff (sys_rst)
        (st_ff == ST_RUN && sleep_exec && !master_clear_pin_low) |=> (!power_down_flag && timeout_flag);
    endproperty
    a_sleep_flags: assert property (p_sleep_flags) else $error("flags wrong after sleep");

    property p_cpu_clk;
        @(posedge mclk) disable iff (sys_rst)
        (st_ff == ST_SLEEP || st_ff == ST_HIB) |-> !cpu_clk_en;
    endproperty
    a_cpu_clk: assert property (p_cpu_clk) else $error("cpu clock runs asleep");

    property p_osc_awake;
        @(posedge mclk) disable iff (sys_rst)
        (st_ff == ST_RUN && $past(st_ff) == ST_RUN) |-> main_osc_en;
    endproperty
    a_osc_awake: assert property (p_osc_awake) else $error("osc off while awake");

    property p_hib_wdt;
        @(posedge mclk) disable iff (sys_rst)
        (st_ff == ST_HIB) |-> (!wdt_run && pullup_disable);
    endproperty
    a_hib_wdt: assert property (p_hib_wdt) else $error("watchdog on in hibernate");

    property p_hib_no_wdt_wake;
        @(posedge mclk) disable iff (sys_rst)
        (st_ff == ST_HIB && !any_irq && !master_clear_pin_low) |=> (st_ff == ST_HIB);
    endproperty
    a_hib_no_wdt_wake: assert property (p_hib_no_wdt_wake) else $error("hibernate left without cause");

    property p_wdt_wake_flag;
        @(posedge mclk) disable iff (sys_rst)
        (wdt_wake && !master_clear_pin_low && !any_irq) |=> (!timeout_flag && st_ff == ST_WAKE);
    endproperty
    a_wdt_wake_flag: assert property (p_wdt_wake_flag) else $error("timeout flag not cleared");

    property p_immediate_wake;
        @(posedge mclk) disable iff (sys_rst)
        (st_ff == ST_RUN && sleep_exec && any_irq && !master_clear_pin_low) |=> (st_ff == ST_WAKE);
    endproperty
    a_immediate_wake: assert property (p_immediate_wake) else $error("pending irq did not wake");

    property p_wake_clear;
        @(posedge mclk) disable iff (sys_rst)
        ((st_ff == ST_SLEEP) && (nxt_st == ST_WAKE)) |=> wdt_clear;
    endproperty
    a_wake_clear: assert property (p_wake_clear) else $error("watchdog not cleared on wake");

    property p_bit6_zero;
        @(posedge mclk) disable iff (sys_rst)
        (wb_ack_o && $past(hit_spc)) |-> (wb_dat_o[6] == 1'b0);
    endproperty
    a_bit6_zero: assert property (p_bit6_zero) else $error("bit 6 read nonzero");

    // Interrupt wake, following instruction done, branch only with global enable
    sequence s_irq_wake_done;
        (st_ff == ST_WAKE) && next_insn_done && wake_irq_ff && gie_latch_ff;
    endsequence
    sequence s_plain_wake_done;
        (st_ff == ST_WAKE) && next_insn_done && !gie_latch_ff;
    endsequence
    property p_vector_after_wake;
        @(posedge mclk) disable iff (sys_rst)
        s_irq_wake_done |=> (vector_req && (vector_addr == IRQ_VECTOR));
    endproperty
    a_vector_after_wake: assert property (p_vector_after_wake) else $error("no vector after irq wake");
    property p_no_vector;
        @(posedge mclk) disable iff (sys_rst)
        s_plain_wake_done |=> !vector_req;
    endproperty
    a_no_vector: assert property (p_no_vector) else $error("vector without global enable");
endmodule
`default_nettype wire

// *** sim/sleep_hibernate_power_control_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module sleep_hibernate_power_control_tb_top
    import pwr_pkg::*;
;
// ======================================================
// Stimulus and observed signals
logic               mclk = 1'h0;
logic               sys_rst = 1'h1;
logic               wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0;
logic [7:0]         wb_adr_i = 8'h00;
logic [31:0]        wb_dat_i = 32'h0, wb_dat_o, rd;
logic [3:0]         wb_sel_i = 4'hf;
logic               wb_ack_o, wb_err_o, er;
logic               sleep_exec = 1'h0, global_irq_enable = 1'h0, watchdog_config_enable = 1'h1;
logic [12:0]        pc_next = 13'h0, prefetch_addr, vector_addr, exp_pc, pf_addr_seen;
logic [NUM_IRQ-1:0] irq_flags = 6'h00, irq_enables = 6'h00;
logic               next_insn_done = 1'h0, wdt_timeout_pin = 1'h0, master_clear_pin = 1'h1;
logic               cpu_clk_en, prefetch_req, vector_req, device_reset, power_down_flag, timeout_flag;
logic               wdt_clear, wdt_run, port_hold, pullup_disable, input_buffer_gate, main_osc_en;
logic               por_enable, ref_pwr_en, lvl_shift_pwr_en, cmp_pwr_en, temp_pwr_en, conv_pwr_en;
logic [7:0]         v;
int                 error_cnt = 0, check_count = 0, pf_cnt = 0, vec_cnt = 0, clr_cnt = 0, rst_cnt = 0;
int                 p0, v0, c0;
wire logic [4:0]    pwr_on = {ref_pwr_en, lvl_shift_pwr_en, cmp_pwr_en, temp_pwr_en, conv_pwr_en};

sleep_hibernate_power_control uut (
    .mclk, .sys_rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_dat_o,
    .wb_ack_o, .wb_err_o, .sleep_exec, .pc_next, .global_irq_enable, .watchdog_config_enable,
    .irq_flags, .irq_enables, .next_insn_done, .cpu_clk_en, .prefetch_req, .prefetch_addr,
    .vector_req, .vector_addr, .device_reset, .power_down_flag, .timeout_flag, .wdt_timeout_pin,
    .wdt_clear, .wdt_run, .master_clear_pin, .port_hold, .pullup_disable, .input_buffer_gate,
    .main_osc_en, .por_enable, .ref_pwr_en, .lvl_shift_pwr_en, .cmp_pwr_en, .temp_pwr_en, .conv_pwr_en
);

// Clock at 40 MHz
always #12.5 mclk = ~mclk;

// ======================================================
// Pulse counters for one-cycle outputs
always @(posedge mclk) begin
    if (prefetch_req === 1'h1) begin
        pf_cnt <= pf_cnt + 1;
        pf_addr_seen <= prefetch_addr;
    end
    if (vector_req === 1'h1 && vector_addr === IRQ_VECTOR) begin
        vec_cnt <= vec_cnt + 1;
    end
    if (wdt_clear === 1'h1) begin
        clr_cnt <= clr_cnt + 1;
    end
    if (device_reset === 1'h1) begin
        rst_cnt <= rst_cnt + 1;
    end
end

// ======================================================
// Expectations and checking
function automatic logic [4:0] exp_pwr(input logic [7:0] r);
    return ~{r[REF_OFF_BIT], r[LS_OFF_BIT], r[CMP_OFF_BIT], r[TEMP_OFF_BIT], r[CONV_OFF_BIT]};
endfunction

task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
        error_cnt++;
        $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
endtask

task automatic report_and_stop();
    if (error_cnt == 0 && check_count > 0) begin
        $display("TEST PASSED");
    end else begin
        $display("TEST FAILED");
    end
    $finish;
endtask

// Exhausted wait counts as a mismatch
task automatic bail();
    error_cnt++;
    report_and_stop();
endtask

task automatic tick(input int n);
    repeat (n) @(posedge mclk);
endtask

task automatic wait_lvl(ref logic s, input logic lvl);
    for (int i = 0; i < 40 && s !== lvl; i++) @(posedge mclk);
    if (s !== lvl) bail();
endtask

// ======================================================
// Classic single Wishbone cycle, waits for ack or err
task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    logic got;
    got = 1'h0;
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= {24'h0, d};
    for (int i = 0; i < 16 && !got; i++) begin
        @(posedge mclk);
        if (wb_ack_o === 1'h1 || wb_err_o === 1'h1) begin
            got = 1'h1;
            rd = wb_dat_o;
            er = wb_err_o;
        end
    end
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
    wb_we_i <= 1'h0;
    if (!got) bail();
    @(posedge mclk);
endtask

// Sleep instruction with a random next address
task automatic go_sleep();
    exp_pc = 13'($urandom);
    pc_next <= exp_pc;
    sleep_exec <= 1'h1;
    @(posedge mclk);
    sleep_exec <= 1'h0;
    wait_lvl(cpu_clk_en, 1'h0);
    tick(1);
endtask

// Wait for the clock to return, then finish the following instruction
task automatic finish_wake();
    wait_lvl(cpu_clk_en, 1'h1);
    irq_flags <= 6'h00;
    tick(2);
    next_insn_done <= 1'h1;
    @(posedge mclk);
    next_insn_done <= 1'h0;
    tick(3);
endtask

task automatic wdt_pulse();
    wdt_timeout_pin <= 1'h1;
    tick(6);
    wdt_timeout_pin <= 1'h0;
    tick(6);
endtask

// ======================================================
// Main sequence
initial begin
    void'($urandom(32'hb630ea8e));
    tick(8);
    sys_rst <= 1'h0;
    tick(2);
    // Reset state and register map
    chk({cpu_clk_en, main_osc_en, por_enable, port_hold, power_down_flag, timeout_flag}, 6'h3b);
    wb(1'h0, SPC_OFFSET, 8'h00);
    chk(rd, 32'h3f);
    chk(pwr_on, exp_pwr(8'h3f));
    wb(1'h1, STAT_OFFSET, 8'h00);
    wb(1'h0, STAT_OFFSET, 8'h00);
    chk(rd[3:0], 4'h3);
    wb(1'h0, 8'h20, 8'h00);
    chk(er, 1'h1);
    wb_sel_i <= 4'he;
    wb(1'h1, SPC_OFFSET, 8'h00);
    wb_sel_i <= 4'hf;
    wb(1'h0, SPC_OFFSET, 8'h00);
    chk(rd, 32'h3f);
    // Random control values, bit 6 and power enables
    for (int i = 0; i < 8; i++) begin
        v = 8'($urandom);
        wb(1'h1, SPC_OFFSET, v);
        wb(1'h0, SPC_OFFSET, 8'h00);
        chk(rd, {24'h0, v & SPC_IMPL_MASK});
        chk(pwr_on, exp_pwr(v));
    end
    watchdog_config_enable <= 1'h0;
    tick(3);
    chk(wdt_run, 1'h0);
    watchdog_config_enable <= 1'h1;
    // Each interrupt source, with and without its enable
    for (int s = 0; s < NUM_IRQ; s++) begin
        wb(1'h1, SPC_OFFSET, 8'($urandom) & 8'h77);
        global_irq_enable <= s[0];
        p0 = pf_cnt;
        v0 = vec_cnt;
        c0 = clr_cnt;
        go_sleep();
        chk({power_down_flag, timeout_flag, main_osc_en, por_enable, port_hold}, 5'h0d);
        chk(32'(pf_cnt - p0), 32'h1);
        chk({19'h0, pf_addr_seen}, {19'h0, exp_pc});
        chk(wdt_run, 1'h1);
        irq_enables <= ~(6'h01 << s);
        irq_flags <= 6'h01 << s;
        tick(6);
        chk(cpu_clk_en, 1'h0);
        irq_enables <= 6'h3f;
        finish_wake();
        chk(32'(vec_cnt - v0), 32'(s % 2));
        chk(32'(clr_cnt - c0), 32'h2);
    end
    // Watchdog wake with the main oscillator off in sleep
    wb(1'h1, SPC_OFFSET, 8'h08);
    go_sleep();
    chk(main_osc_en, 1'h0);
    wdt_pulse();
    finish_wake();
    chk({timeout_flag, main_osc_en, device_reset}, 3'h2);
    // Hibernate ignores the watchdog
    wb(1'h1, SPC_OFFSET, 8'h80);
    go_sleep();
    chk({wdt_run, pullup_disable, input_buffer_gate, por_enable}, 4'h6);
    wb(1'h0, STAT_OFFSET, 8'h00);
    chk(rd[3:2], 2'h2);
    wdt_pulse();
    chk(cpu_clk_en, 1'h0);
    irq_flags <= 6'h01;
    finish_wake();
    chk({pullup_disable, wdt_run}, 2'h1);
    // Pending enabled interrupt at entry, global enable clear
    global_irq_enable <= 1'h0;
    irq_flags <= 6'h10;
    sleep_exec <= 1'h1;
    @(posedge mclk);
    sleep_exec <= 1'h0;
    tick(3);
    wb(1'h0, STAT_OFFSET, 8'h00);
    chk(rd[3:0], 4'he);
    finish_wake();
    // Master clear wake resets the device
    wb(1'h1, SPC_OFFSET, 8'h00);
    c0 = rst_cnt;
    go_sleep();
    master_clear_pin <= 1'h0;
    tick(8);
    master_clear_pin <= 1'h1;
    tick(8);
    chk({31'h0, rst_cnt != c0}, 32'h1);
    chk(cpu_clk_en, 1'h1);
    wb(1'h0, SPC_OFFSET, 8'h00);
    chk(rd, 32'h3f);
    report_and_stop();
end
endmodule
`default_nettype wire
